/* File: inc/mem_cfg_pkg.sv */
// Constants and types for the memory-map configuration register bank.
// Assumes an 8-bit register index and byte-wide registers on a plain port.
package mem_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int STRAP_W = 3;
    localparam int MEM_ADDR_W = 24;
    localparam int SHADOW_WIN_N = 16;

    // Register indexes
    localparam logic [7:0] IDX_MEM_CFG   = 8'h66;
    localparam logic [7:0] IDX_WIN_A_EXT = 8'h67;
    localparam logic [7:0] IDX_SHADOW_CD = 8'h68;
    localparam logic [7:0] IDX_SHADOW_EF = 8'h69;
    localparam logic [7:0] IDX_RSVD      = 8'h6A;

    // Reset values and the reserved-slot read value
    localparam logic [7:0] RST_MEM_CFG   = 8'h00;
    localparam logic [7:0] RST_WIN_A_EXT = 8'h00;
    localparam logic [7:0] RST_SHADOW_CD = 8'h00;
    localparam logic [7:0] RST_SHADOW_EF = 8'h00;
    localparam logic [7:0] RSVD_READ     = 8'h00;

    // Memory configuration field positions
    localparam int MC_SERIAL_BIT = 7;
    localparam int MC_OPT0_BIT   = 6;
    localparam int MC_OPT1_BIT   = 5;
    localparam int MC_BANK_MSB   = 4;
    localparam int MC_BANK_LSB   = 2;
    localparam int MC_RSVD_BIT   = 1;
    localparam int MC_EPAGE_BIT  = 0;
    localparam logic [7:0] MC_SW_MASK = 8'h1F;

    // Strap vector positions inside the capture block
    localparam int STRAP_SERIAL = 2;
    localparam int STRAP_RTS    = 1;
    localparam int STRAP_DTR    = 0;

    // Shadow area 0C0000h-0FFFFFh: address bits 23:18 and window index
    localparam logic [5:0] SHADOW_SEG = 6'h03;
    localparam int SHADOW_SEG_LSB = 18;
    localparam int SHADOW_IDX_MSB = 17;
    localparam int SHADOW_IDX_LSB = 14;

    typedef enum logic [1:0] {
        BUS_RESERVED = 2'b00,
        BUS_LOCAL_2X = 2'b01,
        BUS_MAX_ISA  = 2'b10
    } bus_option_t;

    typedef enum logic [2:0] {
        BANK_NONE  = 3'b000,
        BANK_1M_X1 = 3'b001,
        BANK_1M_X2 = 3'b010,
        BANK_2M_X1 = 3'b011,
        BANK_2M_X2 = 3'b100,
        BANK_8M_X1 = 3'b101,
        BANK_8M_X2 = 3'b110,
        BANK_UNDEF = 3'b111
    } bank_code_t;

    // Enhanced page needs the two-bank 1-Mbyte layout
    localparam bank_code_t EPAGE_BANK = BANK_1M_X2;

endpackage : mem_cfg_pkg

/* File: inc/mem_cfg_ifs.sv */
// Interfaces joining the register bank to its strap capture and shadow decoder.
// Assumes all parties run on the single core clock.
`timescale 1ns/1ns
interface strap_if;
    import mem_cfg_pkg::*;
    logic [STRAP_W-1:0] latched;
    logic               done;
    modport capture (output latched, output done);
    modport user    (input latched, input done);
endinterface : strap_if

interface shadow_if;
    import mem_cfg_pkg::*;
    logic [MEM_ADDR_W-1:0]   addr;
    logic [SHADOW_WIN_N-1:0] win_en;
    logic                    hit;
    modport requester (output addr, output win_en, input hit);
    modport decoder   (input addr, input win_en, output hit);
endinterface : shadow_if

/* File: verilog/strap_capture.sv */
// Synchronises the three strap pins and latches them once after reset release.
// Assumes the pins hold steady around reset; they are asynchronous to clk.
`timescale 1ns/1ns
module strap_capture
    import mem_cfg_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [STRAP_W-1:0] pins,
    strap_if.capture                cap
);
    typedef enum logic {
        CAP_WAIT = 1'b0,
        CAP_DONE = 1'b1
    } cap_state_t;

    logic [STRAP_W-1:0] s1_r;
    logic [STRAP_W-1:0] s2_r;
    logic [STRAP_W-1:0] s3_r;
    logic [STRAP_W-1:0] latched_r;
    cap_state_t         state_r;

    // Three-stage synchroniser per pin; stage one feeds only stage two
    genvar g;
    for (g = 0; g < STRAP_W; g++) begin : g_sync
        always_ff @(posedge clk) begin
            s1_r[g] <= pins[g];
            s2_r[g] <= s1_r[g];
            s3_r[g] <= s2_r[g];
        end
    end

    // Latch once stages two and three agree, so a pin edge is not caught mid-flight
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= CAP_WAIT;
            latched_r <= '0;
        end else begin
            unique case (state_r)
                CAP_WAIT: begin
                    if (s2_r == s3_r) begin
                        latched_r <= s3_r;
                        state_r   <= CAP_DONE;
                    end
                end
                CAP_DONE: begin
                    state_r <= CAP_DONE;
                end
            endcase
        end
    end

    assign cap.latched = latched_r;
    assign cap.done    = (state_r == CAP_DONE);

endmodule : strap_capture

/* File: verilog/shadow_decode.sv */
// Maps a memory address to one of the sixteen 16-Kbyte shadow windows.
// Assumes the caller registers the hit; this block is pure combinational.
`timescale 1ns/1ns
module shadow_decode
    import mem_cfg_pkg::*;
(
    shadow_if.decoder sh
);
    logic       in_area;
    logic [3:0] win_idx;

    // Every window is a full contiguous 16 Kbytes
    always_comb begin
        in_area = (sh.addr[MEM_ADDR_W-1:SHADOW_SEG_LSB] == SHADOW_SEG);
        win_idx = sh.addr[SHADOW_IDX_MSB:SHADOW_IDX_LSB];
        sh.hit  = in_area && sh.win_en[win_idx];
    end

endmodule : shadow_decode

/* File: verilog/mem_cfg_regs.sv */
// Memory-map configuration register bank: straps, bank size, page mode,
// window-set-A upper address bits and shadow window enables.
// Assumes a plain register port with read data one cycle after the strobe,
// and that ROM configuration and version bits arrive from neighbouring blocks.
//
// Functional notes
// - Request-to-send strap latched, read at bit 6
// - Data-terminal-ready strap latched, read at bit 5
// - Serial output level latched, read at bit 7
// - Strap pair selects reserved, local, or ISA
// - Bank code bits 4-2 select DRAM layout
// - Bit 0 plus select enables enhanced page
// - Pages 7-4 hold bits 22 and 21
// - First shadow register covers C and D
// - Second shadow register covers E and F
// - All shadow enables reset to zero
// - Windows gated by global enable, write gate
`timescale 1ns/1ns
module mem_cfg_regs
    import mem_cfg_pkg::*;
(
    input  wire logic                               clk,
    input  wire logic                               rst,
    // Register port
    input  wire logic [mem_cfg_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [mem_cfg_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [mem_cfg_pkg::DATA_W-1:0]     reg_rdata,
    // Strap pins, sampled after reset
    input  wire logic                               serial_output_pin,
    input  wire logic                               rts_strap_pin,
    input  wire logic                               dtr_strap_pin,
    // Bits owned by neighbouring registers
    input  wire logic                               enhanced_page_select,
    input  wire logic                               alt_dram_select,
    input  wire logic                               shadow_global_en,
    input  wire logic                               shadow_write_gate,
    // Memory cycle being decoded for shadowing
    input  wire logic [mem_cfg_pkg::MEM_ADDR_W-1:0] mem_addr,
    input  wire logic                               mem_wr,
    // Configuration results
    output mem_cfg_pkg::bus_option_t                bus_option,
    output logic                                    straps_valid,
    output logic      [4:0]                         bank0_mbytes,
    output logic      [4:0]                         bank1_mbytes,
    output logic                                    bank_cfg_valid,
    output logic                                    enhanced_page_on,
    output logic      [3:0][1:0]                    page_ext_bits,
    output logic                                    shadow_read_hit,
    output logic                                    shadow_write_hit
);
    import mem_cfg_pkg::*;

    // Carriers to the two helper blocks
    strap_if  strap ();
    shadow_if shadow ();

    // Stored register bytes, the combinational read view and the registered results
    logic [DATA_W-1:0]  mem_cfg_r;
    logic [DATA_W-1:0]  win_a_ext_r;
    logic [DATA_W-1:0]  shadow_cd_r;
    logic [DATA_W-1:0]  shadow_ef_r;
    logic [DATA_W-1:0]  rdata_r;
    logic [DATA_W-1:0]  rdata_nxt;
    logic [DATA_W-1:0]  mem_cfg_view;
    bus_option_t        bus_option_r;
    bus_option_t        bus_option_nxt;
    logic               straps_valid_r;
    logic [4:0]         bank0_r;
    logic [4:0]         bank1_r;
    logic               bank_valid_r;
    logic               epage_r;
    logic               shadow_rd_r;
    logic               shadow_wr_r;
    logic [3:0][1:0]    page_ext_r;
    bank_code_t         bank_code;
    logic               strap_opt0;
    logic               strap_opt1;
    logic               strap_serial;

    // Bank size of one bank, in Mbytes, for a given code
    function automatic logic [4:0] bank_mb(input bank_code_t code, input logic second);
        logic [4:0] mb;
        mb = 5'h00;
        unique case (code)
            BANK_1M_X1: mb = second ? 5'h00 : 5'h01;
            BANK_1M_X2: mb = 5'h01;
            BANK_2M_X1: mb = second ? 5'h00 : 5'h02;
            BANK_2M_X2: mb = 5'h02;
            BANK_8M_X1: mb = second ? 5'h00 : 5'h08;
            BANK_8M_X2: mb = 5'h08;
            BANK_NONE:  mb = 5'h00;
            BANK_UNDEF: mb = 5'h00;
        endcase
        return mb;
    endfunction : bank_mb

    // Strap pins pass a synchroniser before the one-time capture
    // It fires once per reset, so the pins may serve other uses afterwards
    strap_capture u_straps (
        .clk  (clk),
        .rst  (rst),
        .pins ({serial_output_pin, rts_strap_pin, dtr_strap_pin}),
        .cap  (strap.capture)
    );

    // Window lookup over the sixteen shadow enables
    // Pure combinational; the hit is registered below with the enables
    shadow_decode u_shadow (
        .sh (shadow.decoder)
    );

    assign shadow.addr   = mem_addr;
    // Low byte bit 0 is window 0C0000h, high byte bit 7 is window 0FC000h
    assign shadow.win_en = {shadow_ef_r, shadow_cd_r};

    // Captured strap levels stay fixed until the next reset
    assign strap_serial = strap.latched[STRAP_SERIAL];
    assign strap_opt0   = strap.latched[STRAP_RTS];
    assign strap_opt1   = strap.latched[STRAP_DTR];

    // Bank field as an enum so every code is named in the size table
    assign bank_code = bank_code_t'(mem_cfg_r[MC_BANK_MSB:MC_BANK_LSB]);

    // Readable view: latched straps on top, stored software bits below
    always_comb begin
        mem_cfg_view = mem_cfg_r & MC_SW_MASK;
        mem_cfg_view[MC_SERIAL_BIT] = strap_serial;
        mem_cfg_view[MC_OPT0_BIT]   = strap_opt0;
        mem_cfg_view[MC_OPT1_BIT]   = strap_opt1;
    end

    // Memory configuration: only bits 4:0 accept writes
    // Bits 7:5 are strap views; a write there must not reach the capture
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_cfg_r <= RST_MEM_CFG;
        end else if (reg_wr && reg_addr == IDX_MEM_CFG) begin
            mem_cfg_r <= reg_wdata & MC_SW_MASK;
        end
    end

    // Window-set-A extension; software is expected to pre-select set A
    // The set-A or set-B choice lives outside this block, so nothing checks it
    always_ff @(posedge clk) begin
        if (rst) begin
            win_a_ext_r <= RST_WIN_A_EXT;
        end else if (reg_wr && reg_addr == IDX_WIN_A_EXT) begin
            win_a_ext_r <= reg_wdata;
        end
    end

    // First shadow enable register, C and D segments
    always_ff @(posedge clk) begin
        if (rst) begin
            shadow_cd_r <= RST_SHADOW_CD;
        end else if (reg_wr && reg_addr == IDX_SHADOW_CD) begin
            shadow_cd_r <= reg_wdata;
        end
    end

    // Second shadow enable register, E and F segments
    always_ff @(posedge clk) begin
        if (rst) begin
            shadow_ef_r <= RST_SHADOW_EF;
        end else if (reg_wr && reg_addr == IDX_SHADOW_EF) begin
            shadow_ef_r <= reg_wdata;
        end
    end

    // Read mux; the reserved slot and unmapped indexes read as zero
    // A read only looks and never clears anything, so a stray read of any
    // index is harmless
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                IDX_MEM_CFG:   rdata_nxt = mem_cfg_view;
                IDX_WIN_A_EXT: rdata_nxt = win_a_ext_r;
                IDX_SHADOW_CD: rdata_nxt = shadow_cd_r;
                IDX_SHADOW_EF: rdata_nxt = shadow_ef_r;
                IDX_RSVD:      rdata_nxt = RSVD_READ;
                default:       rdata_nxt = '0;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    // Zero in idle cycles, so a stale byte is never taken for an answer
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Bus option from the two latched straps
    // Bus option bit one low is reserved whatever bit zero says
    always_comb begin
        if (!strap_opt1) begin
            bus_option_nxt = BUS_RESERVED;
        end else if (!strap_opt0) begin
            bus_option_nxt = BUS_LOCAL_2X;
        end else begin
            bus_option_nxt = BUS_MAX_ISA;
        end
    end

    // Held at reserved until the straps have been caught
    // Bus logic downstream must never act on a half-synchronised strap
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_option_r   <= BUS_RESERVED;
            straps_valid_r <= 1'b0;
        end else begin
            bus_option_r   <= strap.done ? bus_option_nxt : BUS_RESERVED;
            straps_valid_r <= strap.done;
        end
    end

    // Bank layout applies only while the alternate DRAM select is clear
    // That select hands bank decode to another register, so all reads zero.
    // Codes 000 and 111 have no layout: both sizes zero and valid low
    always_ff @(posedge clk) begin
        if (rst) begin
            bank0_r      <= 5'h00;
            bank1_r      <= 5'h00;
            bank_valid_r <= 1'b0;
        end else if (alt_dram_select) begin
            bank0_r      <= 5'h00;
            bank1_r      <= 5'h00;
            bank_valid_r <= 1'b0;
        end else begin
            bank0_r      <= bank_mb(bank_code, 1'b0);
            bank1_r      <= bank_mb(bank_code, 1'b1);
            bank_valid_r <= (bank_code != BANK_NONE) && (bank_code != BANK_UNDEF);
        end
    end

    // Enhanced page needs this bit, the version select and the 1M x2 layout
    // Registered, so a change in any term takes effect on a single edge
    always_ff @(posedge clk) begin
        if (rst) begin
            epage_r <= 1'b0;
        end else begin
            epage_r <= mem_cfg_r[MC_EPAGE_BIT]
                     && enhanced_page_select
                     && (bank_code == EPAGE_BANK)
                     && !alt_dram_select;
        end
    end

    // Unpack the page 7..4 pairs; index 3 is page 7, bit 1 is address bit 22
    // A register copy rather than wires, so every output comes from a flop;
    // the cost is one cycle of lag after a write
    genvar p;
    for (p = 0; p < 4; p++) begin : g_page
        always_ff @(posedge clk) begin
            if (rst) begin
                page_ext_r[p] <= 2'h0;
            end else begin
                page_ext_r[p] <= win_a_ext_r[2*p+1 -: 2];
            end
        end
    end

    // Per-window hits count only with the global enable; writes also need the gate
    // Decoding is done before the flop, so a hit lags its memory cycle by one
    // clock; a caller needing zero lag would have to decode again itself
    always_ff @(posedge clk) begin
        if (rst) begin
            shadow_rd_r <= 1'b0;
            shadow_wr_r <= 1'b0;
        end else begin
            shadow_rd_r <= shadow.hit && shadow_global_en && !mem_wr;
            shadow_wr_r <= shadow.hit && shadow_global_en && mem_wr
                         && shadow_write_gate;
        end
    end

    // Every output is a flop; no input reaches a pin without a clock edge
    assign reg_rdata        = rdata_r;
    assign bus_option       = bus_option_r;
    assign straps_valid     = straps_valid_r;
    assign bank0_mbytes     = bank0_r;
    assign bank1_mbytes     = bank1_r;
    assign bank_cfg_valid   = bank_valid_r;
    assign enhanced_page_on = epage_r;
    assign page_ext_bits    = page_ext_r;
    assign shadow_read_hit  = shadow_rd_r;
    assign shadow_write_hit = shadow_wr_r;

endmodule : mem_cfg_regs

/* File: test/mem_cfg_regs_assertions.sv */
// Port checker for the memory-map configuration bank.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module mem_cfg_regs_checker
    import mem_cfg_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic             enhanced_page_select,
    input wire logic             alt_dram_select,
    input wire logic             shadow_global_en,
    input wire logic             shadow_write_gate,
    input wire logic [23:0]      mem_addr,
    input wire logic             mem_wr,
    input wire bus_option_t      bus_option,
    input wire logic             straps_valid,
    input wire logic [4:0]       bank0_mbytes,
    input wire logic [4:0]       bank1_mbytes,
    input wire logic             bank_cfg_valid,
    input wire logic             enhanced_page_on,
    input wire logic [3:0][1:0]  page_ext_bits,
    input wire logic             shadow_read_hit,
    input wire logic             shadow_write_hit
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Reserved and unmapped reads answer zero
    a_rsvd_reads_zero: assert property (reg_rd && (reg_addr == IDX_RSVD ||
        reg_addr < IDX_MEM_CFG || reg_addr > IDX_RSVD) |=> reg_rdata == 8'h00)
        else $error("reserved index read not zero");
    // Bus option must agree with the strap bits software reads back
    a_bus_opt_match: assert property (straps_valid && $past(straps_valid) &&
        $past(reg_rd) && $past(reg_addr) == IDX_MEM_CFG |-> bus_option ==
        (!reg_rdata[5] ? BUS_RESERVED : reg_rdata[6] ? BUS_MAX_ISA : BUS_LOCAL_2X))
        else $error("bus option disagrees with strap bits");
    a_straps_hold: assert property (straps_valid |=> straps_valid && $stable(bus_option))
        else $error("captured straps changed without reset");
    a_bank_sizes: assert property (bank_cfg_valid |-> bank0_mbytes inside
        {5'h01, 5'h02, 5'h08} && (bank1_mbytes == 5'h00 || bank1_mbytes == bank0_mbytes))
        else $error("illegal bank sizes");
    a_alt_disables: assert property (alt_dram_select [*2] |=>
        !bank_cfg_valid && !enhanced_page_on) else $error("alternate select ignored");
    a_epage_needs: assert property (enhanced_page_on |-> $past(enhanced_page_select) &&
        bank0_mbytes == 5'h01 && bank1_mbytes == 5'h01) else $error("page mode wrongly on");
    a_page_ext_write: assert property (reg_wr && reg_addr == IDX_WIN_A_EXT ##1
        !(reg_wr && reg_addr == IDX_WIN_A_EXT) |=> page_ext_bits == $past(reg_wdata, 2))
        else $error("extension bits not as written");
    a_shadow_outside: assert property (mem_addr[23:18] != SHADOW_SEG |=>
        !shadow_read_hit && !shadow_write_hit) else $error("hit outside shadow area");
    a_global_gate: assert property (!shadow_global_en |=>
        !shadow_read_hit && !shadow_write_hit) else $error("hit without global enable");
    a_write_gate: assert property (!(mem_wr && shadow_write_gate) |=> !shadow_write_hit)
        else $error("write hit without write permit");
    a_shadow_reset: assert property ($past(rst, 2) |-> !shadow_read_hit &&
        !shadow_write_hit) else $error("shadow hit right after reset");

    c_epage: cover property (enhanced_page_on);
    c_write_hit: cover property (shadow_write_hit);
    c_max_isa: cover property (straps_valid && bus_option == BUS_MAX_ISA);
endmodule : mem_cfg_regs_checker

bind mem_cfg_regs mem_cfg_regs_checker mem_cfg_regs_checker_inst (.clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .enhanced_page_select, .alt_dram_select,
    .shadow_global_en, .shadow_write_gate, .mem_addr, .mem_wr, .bus_option, .straps_valid,
    .bank0_mbytes, .bank1_mbytes, .bank_cfg_valid, .enhanced_page_on, .page_ext_bits,
    .shadow_read_hit, .shadow_write_hit);

/* File: test/mem_cfg_regs_test.sv */
// Self-checking bench for the memory-map configuration bank.
// Assumes the bench is the top module and drives all of the bank's inputs.
`timescale 1ns/1ns
module mem_cfg_regs_test;
    import mem_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic serial_output_pin = 1'b0;
    logic rts_strap_pin = 1'b0;
    logic dtr_strap_pin = 1'b0;
    logic enhanced_page_select = 1'b0;
    logic alt_dram_select = 1'b0;
    logic shadow_global_en = 1'b1;
    logic shadow_write_gate = 1'b1;
    logic [23:0] mem_addr = 24'h0C0000;
    logic mem_wr = 1'b0;
    logic [7:0] reg_rdata;
    bus_option_t bus_option;
    logic straps_valid, bank_cfg_valid, enhanced_page_on, shadow_read_hit, shadow_write_hit;
    logic [4:0] bank0_mbytes, bank1_mbytes;
    logic [3:0][1:0] page_ext_bits;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int sw66, ext67, shadow_en, straps, c, a, e, m, v, w, g, gt, h;
    int b0t[8] = '{0, 1, 1, 2, 2, 8, 8, 0};
    int b1t[8] = '{0, 0, 1, 0, 2, 0, 8, 0};
    int idx[9] = '{8'h66, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h00, 8'h65, 8'h6B, 8'hFF};
    logic [23:0] ad;

    mem_cfg_regs mem_cfg_regs_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .serial_output_pin, .rts_strap_pin, .dtr_strap_pin, .enhanced_page_select,
        .alt_dram_select, .shadow_global_en, .shadow_write_gate, .mem_addr, .mem_wr,
        .bus_option, .straps_valid, .bank0_mbytes, .bank1_mbytes, .bank_cfg_valid,
        .enhanced_page_on, .page_ext_bits, .shadow_read_hit, .shadow_write_hit);

    always #4 clk = ~clk;

    // Hang guard: the whole run needs a few thousand cycles at most
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Model read value; strap bits sit above the software field
    function automatic int rexp(input int ra);
        case (ra)
            8'h66: return (straps << 5) | (sw66 & 8'h1F);
            8'h67: return ext67;
            8'h68: return shadow_en & 8'hFF;
            8'h69: return shadow_en >> 8;
            default: return 0;
        endcase
    endfunction : rexp

    // Write strobe for one cycle; waits an edge first so two writes never merge
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ra;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read strobe starts at once, so a read may follow a write with no gap
    task automatic rd(input logic [7:0] ra);
        reg_rd <= 1'b1;
        reg_addr <= ra;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, rexp(ra), "read data");
        @(posedge clk);
    endtask : rd

    // Pins held steady through reset and long after, as capture needs
    task automatic do_reset(input int pins);
        int n;
        rst <= 1'b1;
        {serial_output_pin, rts_strap_pin, dtr_strap_pin} <= pins[2:0];
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sw66 = 0;
        ext67 = 0;
        shadow_en = 0;
        straps = pins & 7;
        n = 0;
        while (straps_valid !== 1'b1 && n < 12) begin
            @(posedge clk);
            n++;
        end
        chk(straps_valid, 1, "strap capture");
        chk(bus_option, !pins[0] ? BUS_RESERVED : pins[1] ? BUS_MAX_ISA : BUS_LOCAL_2X,
            "bus option");
    endtask : do_reset

    initial begin
        void'($urandom(32'hB3B3));
        do_reset($urandom_range(7));
        wr(8'h6A, 8'h00);
        wr(8'h65, 8'hFF);
        rd(8'h6A);
        rd(8'h65);
        $display("test refused places done");
        for (int k = 0; k < 8; k++) begin
            ext67 = $urandom_range(255);
            wr(8'h67, ext67[7:0]); // set A is pre-selected upstream
            rd(8'h67);
            @(negedge clk);
            chk(page_ext_bits, ext67, "extension bits");
        end
        $display("test extension done");
        // Bank codes with and without the alternate select
        for (int k = 0; k < 24; k++) begin
            c = k % 8;
            a = (k / 8 == 1);
            e = (c == 2 && !a) ? 1 : $urandom_range(1);
            m = (c == 2 && k < 8) ? 1 : $urandom_range(1);
            @(posedge clk);
            alt_dram_select <= a[0];
            enhanced_page_select <= e[0];
            sw66 = (c << 2) | 2 | m;
            wr(8'h66, sw66[7:0]);
            @(posedge clk);
            @(negedge clk);
            v = (c >= 1 && c <= 6 && !a);
            if (!a) begin
                chk(bank0_mbytes, b0t[c], "bank0 size");
                chk(bank1_mbytes, b1t[c], "bank1 size");
            end
            chk(bank_cfg_valid, v, "bank valid");
            chk(enhanced_page_on, v && c == 2 && e && m, "page mode");
        end
        $display("test bank codes done");
        shadow_en = $urandom_range(16'hFFFF);
        wr(8'h68, shadow_en[7:0]);
        rd(8'h68);
        wr(8'h69, shadow_en[15:8]);
        rd(8'h69);
        // Every window, both cycle kinds, window top ends included, then outside
        for (int k = 0; k < 64; k++) begin
            w = $urandom_range(1);
            g = ($urandom_range(3) != 0);
            gt = ($urandom_range(3) != 0);
            ad = 24'h0C0000 + (k % 16) * 24'h004000;
            ad = ad + ((k % 3 == 0) ? 24'h003FFF : $urandom_range(16'h3FFF));
            if (k >= 56) ad = (k % 2) ? 24'h0BFFFF : 24'h100000 + $urandom_range(16'hFFFF);
            @(posedge clk);
            mem_addr <= ad;
            mem_wr <= w[0];
            shadow_global_en <= g[0];
            shadow_write_gate <= gt[0];
            @(posedge clk);
            @(negedge clk);
            h = (ad[23:18] == SHADOW_SEG) && g && shadow_en[ad[17:14]];
            chk({shadow_read_hit, shadow_write_hit}, {h && !w, h && w && gt}, "hit");
        end
        $display("test shadow windows done");
        // Every strap combination; register resets checked after each
        for (int p = 0; p < 8; p++) begin
            @(posedge clk);
            do_reset(p);
            foreach (idx[i]) rd(idx[i][7:0]);
            sw66 = 8'hFF;
            wr(8'h66, 8'hFF);
            rd(8'h66);
        end
        $display("test straps done");
        tally_and_finish();
    end
endmodule : mem_cfg_regs_test
